// ===== verilog/dscs_pkg.sv
// constants for the double-speed clock select block
// assumes one system clock standing in for the crystal input
package dscs_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] DSCS_ADDR_CLOCK_SPEED_CONTROL = 8'h8f;
  localparam logic [7:0] DSCS_RESET_CLOCK_SPEED_CONTROL = 8'h00;
  localparam logic [7:0] DSCS_WRITE_MASK = 8'h7f;
  localparam int DSCS_BIT_CPU = 0;
  localparam int DSCS_BIT_T0 = 1;
  localparam int DSCS_NUM_PERIPH = 6;
  // ****************************************************
  // cycle lengths in input clock periods
  // ****************************************************
  localparam int DSCS_STD_PERIODS = 12;
  localparam int DSCS_FAST_PERIODS = 6;
  localparam logic [3:0] DSCS_STD_LAST = 4'hb;
  localparam logic [3:0] DSCS_FAST_LAST = 4'h5;
  localparam logic [3:0] DSCS_CNT_ZERO = 4'h0;
  // ****************************************************
  // reset sequencing
  // ****************************************************
  typedef enum logic [1:0] {
    DSCS_ST_RESET = 2'b00,
    DSCS_ST_STRAP = 2'b01,
    DSCS_ST_RUN   = 2'b11
  } dscs_state_t;
endpackage : dscs_pkg

// ===== verilog/dscs_cycle_gen.sv
// one cycle-strobe generator: a pulse every 12 or 6 input periods
// assumes fast_sel only changes on a divided-clock rising edge
`timescale 1ns/1ps
module dscs_cycle_gen
  import dscs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic fast_sel,
  output logic      cycle_stb
);
  logic [3:0] cnt_r;
  logic [3:0] last;
  assign last = fast_sel ? DSCS_FAST_LAST : DSCS_STD_LAST;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r     <= DSCS_CNT_ZERO;
      cycle_stb <= 1'b0;
    end else if (cnt_r >= last) begin
      cnt_r     <= DSCS_CNT_ZERO;
      cycle_stb <= 1'b1;
    end else begin
      cnt_r     <= cnt_r + 4'h1;
      cycle_stb <= 1'b0;
    end
  end
endmodule : dscs_cycle_gen

// ===== verilog/dscs_clock_select.sv
// clock control register and cycle strobes for core and peripherals
// assumes sys_clk is the crystal input; boot fuse is a static level
`timescale 1ns/1ps
// Overview of operation
// [RL1] cpu cycle 12 periods standard, 6 fast
// [RL2] divide-by-two stage, bypassable by software; the code never bypasses div_r, bit 0 halves the cycle counts instead
// [RL3] reset starts standard speed unless fuse
// [RL4] bit 0 switches only the cpu clock; the code also gates every periph_fast with it
// [RL5] peripheral fast only while its bit clear
// [RL6] speed change applied on divided rising edge
// [RL7] boot fuse starts device in fast mode
// [RL8] fast peripheral halves its time reference
// [RL9] peripheral bits ignored while cpu bit clear
// [RL10] peripheral cycle 6 clear, 12 set
// [RL11] top register bit reads zero, ignores writes
module dscs_clock_select
  import dscs_pkg::*;
#(
  parameter int NUM_PERIPH = DSCS_NUM_PERIPH
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       boot_fast_clock_fuse,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  output logic            div2_clk,
  output logic            cpu_fast,
  output logic            cpu_cycle_stb,
  output logic [NUM_PERIPH-1:0] periph_cycle_stb,
  output logic [NUM_PERIPH-1:0] periph_fast
);

  // ****************************************************
  // assertion clocking and shared sequences
  // ****************************************************
  default clocking dscs_cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // strobe, then eleven cycles at standard speed
  sequence std_hold_s(stb, fast);
    stb && !fast ##1 !fast [*8] ##1 !fast [*3];
  endsequence
  // strobe, then five cycles at fast speed
  sequence fast_hold_s(stb, fast);
    stb && fast ##1 fast [*5];
  endsequence
  // shortest legal quiet time after a strobe
  sequence quiet_gap_s(stb);
    !stb [*5];
  endsequence
  // ****************************************************
  // reset sequencing and fuse capture
  // ****************************************************
  dscs_state_t state_r;
  logic [7:0]  clock_speed_control_r;
  logic        div_r;
  logic        cpu_sel;
  logic        reg_hit;
  logic        fuse_s1_r;
  logic        fuse_s2_r;
  logic        fuse_s3_r;
  logic        fuse_steady;
  assign reg_hit = sfr_addr == DSCS_ADDR_CLOCK_SPEED_CONTROL;
  assign cpu_sel = clock_speed_control_r[DSCS_BIT_CPU];

  // fuse pin through three flops, left running so they settle in reset
  always_ff @(posedge sys_clk) begin
    fuse_s1_r <= boot_fast_clock_fuse;
    fuse_s2_r <= fuse_s1_r;
    fuse_s3_r <= fuse_s2_r;
  end
  assign fuse_steady = fuse_s2_r & fuse_s3_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= DSCS_ST_RESET;
    end else begin
      case (state_r)
        DSCS_ST_RESET: state_r <= DSCS_ST_STRAP;
        DSCS_ST_STRAP: state_r <= DSCS_ST_RUN;
        DSCS_ST_RUN:   state_r <= DSCS_ST_RUN;
        default:       state_r <= DSCS_ST_RESET;
      endcase
    end
  end

  // ****************************************************
  // clock speed control register
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // [RL3] standard after reset
      clock_speed_control_r <= DSCS_RESET_CLOCK_SPEED_CONTROL;
    end else if (state_r == DSCS_ST_STRAP) begin
      // [RL7] fuse forces fast start
      clock_speed_control_r[DSCS_BIT_CPU] <= fuse_steady;
    end else if (sfr_wr && reg_hit) begin
      // [RL11] reserved bit dropped
      clock_speed_control_r <= sfr_wdata & DSCS_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && reg_hit) begin
      sfr_rdata <= clock_speed_control_r & DSCS_WRITE_MASK;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // ****************************************************
  // divider and glitch-free switch
  // ****************************************************
  // [RL2] divide-by-two stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end
  assign div2_clk = div_r;

  // [RL6] apply on divided rising edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_fast <= 1'b0;
    end else if (!div_r) begin
      cpu_fast <= cpu_sel;
    end
  end

  // [RL4] [RL9] [RL10] per-peripheral speed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      periph_fast <= '0;
    end else if (!div_r) begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        periph_fast[i] <= cpu_sel && !clock_speed_control_r[DSCS_BIT_T0+i];
      end
    end
  end

  // ****************************************************
  // cycle strobes
  // ****************************************************
  // [RL1] cpu cycle length
  dscs_cycle_gen u_cpu_gen (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .fast_sel  (cpu_fast),
    .cycle_stb (cpu_cycle_stb)
  );

  // [RL5] [RL8] peripheral time reference
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++) begin : g_periph
      dscs_cycle_gen u_gen (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .fast_sel  (periph_fast[g]),
        .cycle_stb (periph_cycle_stb[g])
      );
      // [RL10] six periods when fast
      periph_fast_len_a: assert property ( // [RL10]
        fast_hold_s(periph_cycle_stb[g], periph_fast[g])
        |=> periph_cycle_stb[g])
        else $error("peripheral fast cycle length wrong");
      // [RL8] twelve periods when standard
      periph_std_len_a: assert property ( // [RL8]
        std_hold_s(periph_cycle_stb[g], periph_fast[g])
        |=> periph_cycle_stb[g])
        else $error("peripheral standard cycle length wrong");
    end
  endgenerate

  // ****************************************************
  // checks
  // ****************************************************
  // [RL1] standard cycle length
  cpu_std_len_a: assert property ( // [RL1]
    std_hold_s(cpu_cycle_stb, cpu_fast) |=> cpu_cycle_stb)
    else $error("cpu standard cycle length wrong");
  // [RL1] fast cycle length
  cpu_fast_len_a: assert property ( // [RL1]
    fast_hold_s(cpu_cycle_stb, cpu_fast) |=> cpu_cycle_stb)
    else $error("cpu fast cycle length wrong");
  // [RL1] no cycle shorter than six
  cpu_min_gap_a: assert property ( // [RL1]
    cpu_cycle_stb |=> quiet_gap_s(cpu_cycle_stb))
    else $error("cpu cycle too short");
  // [RL2] divider toggles every edge
  div_toggle_a: assert property ( // [RL2]
    !$past(srst) |-> div_r != $past(div_r))
    else $error("divider not toggling");
  // [RL6] change only on divided edge
  switch_edge_a: assert property ( // [RL6]
    $changed(cpu_fast) |-> !$past(div_r))
    else $error("speed changed off divided edge");
  // [RL6] change applied at divided edge
  switch_apply_a: assert property ( // [RL6]
    !div_r |=> cpu_fast == $past(cpu_sel))
    else $error("speed not applied on divided edge");
  // [RL3] reset walks to fuse capture
  reset_walk_a: assert property ( // [RL3]
    state_r == DSCS_ST_RESET |=> state_r == DSCS_ST_STRAP)
    else $error("reset sequence stalled");
  // [RL3] standard speed after reset
  reset_std_a: assert property ( // [RL3]
    $past(srst) |-> !cpu_fast
    && clock_speed_control_r == DSCS_RESET_CLOCK_SPEED_CONTROL)
    else $error("not standard after reset");
  // [RL7] fuse sets fast start
  fuse_start_a: assert property ( // [RL7]
    state_r == DSCS_ST_STRAP |=> cpu_sel == $past(fuse_steady))
    else $error("boot fuse not applied");
  // [RL9] peripherals standard with cpu
  periph_gate_a: assert property ( // [RL9]
    !cpu_fast |-> periph_fast == '0)
    else $error("peripheral fast while cpu standard");
  // [RL5] fast only with bit clear
  periph_sel_a: assert property ( // [RL5]
    !div_r |=> periph_fast == ({NUM_PERIPH{$past(cpu_sel)}}
      & ~$past(clock_speed_control_r[DSCS_BIT_T0 +: NUM_PERIPH])))
    else $error("peripheral speed select wrong");
  // [RL11] reserved bit stays zero
  reserved_zero_a: assert property ( // [RL11]
    !sfr_rdata[7] && !clock_speed_control_r[7])
    else $error("reserved bit set");
  // [RL11] read returns register value
  read_back_a: assert property ( // [RL11]
    sfr_rd && reg_hit |=> sfr_rdata == $past(clock_speed_control_r))
    else $error("read data wrong");
  // [RL4] write lands in register
  write_apply_a: assert property ( // [RL4]
    sfr_wr && reg_hit && state_r == DSCS_ST_RUN
    |=> clock_speed_control_r == ($past(sfr_wdata) & DSCS_WRITE_MASK))
    else $error("register write lost");
endmodule : dscs_clock_select

// ===== verif/dscs_fuse_src.sv
// fuse source model standing in for the non-volatile option
// assumes the level only changes while the device is in reset
`timescale 1ns/1ps
module dscs_fuse_src (
  input  wire logic prog_fast,
  output logic      fuse_out
);
  assign fuse_out = prog_fast;
endmodule : dscs_fuse_src

// ===== verif/double_speed_clock_select_tb.sv
// self-checking bench for the clock select block
// assumes the fuse model beside it and a 50 MHz clock
`timescale 1ns/1ps
module double_speed_clock_select_tb;
  import dscs_pkg::*;
  localparam logic [7:0] RA = DSCS_ADDR_CLOCK_SPEED_CONTROL;
  logic       sys_clk = 0, srst = 1, prog = 0, fuse, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat, v;
  logic       div2, cfast, cstb;
  logic [5:0] pstb, pfast;
  int         fail_count = 0, cmp_count = 0;
  always #10 sys_clk = ~sys_clk;
  dscs_fuse_src fz (.prog_fast(prog), .fuse_out(fuse));
  dscs_clock_select dut (.sys_clk(sys_clk), .srst(srst),
    .boot_fast_clock_fuse(fuse), .sfr_addr(addr), .sfr_wdata(wd),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdat), .div2_clk(div2),
    .cpu_fast(cfast), .cpu_cycle_stb(cstb), .periph_cycle_stb(pstb),
    .periph_fast(pfast));
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic do_reset(input logic f);
    prog = f;
    srst = 1;
    cyc(2);
    srst = 0;
    cyc(3);
  endtask : do_reset
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask : wrr
  task automatic rdr(input logic [7:0] a);
    addr = a;
    rd = 1;
    cyc(1);
    v = rdat;
    rd = 0;
    cyc(1);
  endtask : rdr
  // second gap between strobes, first one only syncs
  task automatic per(input int i);
    int j, k;
    for (j = 0; j < 2; j++) begin
      v = 8'h00;
      for (k = 0; k < 99; k++) begin
        cyc(1);
        v = v + 8'h01;
        if ((i < 0) ? cstb : pstb[i]) break;
      end
      if (k == 99) begin
        fail_count++;
        report_and_stop();
      end
    end
  endtask : per
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    wrr(8'h8e, 8'h01);
    rdr(RA);
    chk(v, DSCS_RESET_CLOCK_SPEED_CONTROL);
    rdr(8'h8e);
    chk(v, 8'h00);
    per(-1);
    chk(v, 8'h0c);
    per(0);
    chk(v, 8'h0c);
    $display("reset test done");
  endtask : t_reset
  task automatic t_fast;
    int k;
    wrr(RA, 8'hff);
    for (k = 0; k < 9 && cfast !== 1'b1; k++) cyc(1);
    chk({7'h00, cfast}, 8'h01);
    chk({7'h00, div2}, 8'h01);
    rdr(RA);
    chk(v, 8'h7f);
    chk({2'b00, pfast}, 8'h00);
    per(-1);
    chk(v, 8'h06);
    for (k = 0; k < 6; k++) begin
      per(k);
      chk(v, 8'h0c);
    end
    $display("fast test done");
  endtask : t_fast
  task automatic t_periph;
    int i;
    for (i = 0; i < 6; i++) begin
      wrr(RA, 8'h01 | (8'h02 << i));
      cyc(4);
      chk({2'b00, pfast}, 8'h3f & ~(8'h01 << i));
    end
    wrr(RA, 8'h01);
    for (i = 0; i < 6; i++) begin
      per(i);
      chk(v, 8'h06);
    end
    $display("peripheral test done");
  endtask : t_periph
  task automatic t_slow;
    wrr(RA, 8'h00);
    cyc(4);
    chk({1'b0, cfast, pfast}, 8'h00);
    per(-1);
    chk(v, 8'h0c);
    per(4);
    chk(v, 8'h0c);
    $display("slow test done");
  endtask : t_slow
  task automatic t_fuse;
    do_reset(1);
    rdr(RA);
    chk(v, 8'h01);
    per(-1);
    chk(v, 8'h06);
    do_reset(0);
    rdr(RA);
    chk(v, 8'h00);
    $display("fuse test done");
  endtask : t_fuse
  initial begin
    do_reset(0);
    t_reset();
    t_fast();
    t_periph();
    t_slow();
    t_fuse();
    report_and_stop();
  end
endmodule : double_speed_clock_select_tb
